// *** supv_pkg.sv ***
// constants, types and rule summary for the supervisor reset and watchdog core
// Summary of operation
// - backup_selected_flag high while switched supply comes from backup cell, else low.
// - supply-low flag low while sensed supply is under threshold, high at once after.
// - active-high reset output is always the complement of active-low reset.
// - select high or floating: reset delay and watchdog timeout from internal oscillator.
// - select low: timing taken from the external timing source input.
// - external clock on timing source input times both reset delay and watchdog.
// - internal timing: timing source input level picks short or long watchdog period.
// - watchdog output goes low when kick input stays steady beyond active timeout.
// - watchdog output stays low until the next kick edge, then goes high.
// - watchdog output stays high while kick input is floating or mid-supply.
// - watchdog output forced high whenever supply-low flag becomes active.
// - active-low reset held asserted while sensed supply stays under threshold.
// - after supply rises above threshold, reset stays asserted 50 ms then releases.
// - backup cell selected only if supply under threshold and main below backup.
// - external clock: watchdog 1024 clocks, 4096 after reset, reset active 512 clocks.
// - every kick edge restarts watchdog; long period after reset until first kick edge.
// - watchdog disabled entirely while the kick-input-valid indication is false.
// - watchdog expiry pulses reset for 50 ms, watchdog restarts at end of that reset.
package supv_pkg;
	localparam int unsigned CLK_HZ = 250_000_000;
	localparam int unsigned OSC_HZ = 10_240;
	localparam int unsigned RESET_ACTIVE_MS = 50;
	localparam int unsigned WD_SHORT_MS = 100;
	localparam int unsigned WD_LONG_MS = 1600;
	localparam logic [15:0] OSC_DIV_DEFAULT = 16'(CLK_HZ / OSC_HZ);
	localparam logic [15:0] RESET_TICKS = 16'(RESET_ACTIVE_MS * OSC_HZ / 1000);
	localparam logic [15:0] WD_SHORT_TICKS = 16'(WD_SHORT_MS * OSC_HZ / 1000);
	localparam logic [15:0] WD_LONG_TICKS_DEFAULT = 16'(WD_LONG_MS * OSC_HZ / 1000);
	localparam logic [15:0] EXT_WD_NORMAL_CLKS = 16'h0400;
	localparam logic [15:0] EXT_WD_AFTER_RESET_CLKS = 16'h1000;
	localparam logic [15:0] EXT_RESET_CLKS = 16'h0200;
	localparam int unsigned AXI_AW = 8;
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_EVENT = 8'h04;
	localparam logic [7:0] REG_EVENT_CLEAR = 8'h08;
	localparam logic [7:0] REG_EVENT_ENABLE = 8'h0C;
	localparam logic [3:0] EVENT_ENABLE_RESET = 4'h0;
	localparam int unsigned EV_WD_EXPIRE = 0;
	localparam int unsigned EV_SUPPLY_LOW = 1;
	localparam int unsigned EV_RESET_RELEASE = 2;
	localparam int unsigned EV_BACKUP = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		SUPV_HOLD = 2'h0,
		SUPV_DELAY = 2'h1,
		SUPV_RUN = 2'h3
	} supv_rst_state_t;
endpackage

// *** supv_time_if.sv ***
// timebase signals passed from the tick generator to the core
`timescale 1ns/10ps
interface supv_time_if;
	logic tick;
	logic ext_sel;
	logic fast_sel;
	modport src (output tick, output ext_sel, output fast_sel);
	modport dst (input tick, input ext_sel, input fast_sel);
endinterface

// *** supv_timebase.sv ***
// tick generator: internal oscillator divider or external clock edge
`timescale 1ns/10ps
module supv_timebase #(
	parameter logic [15:0] OSC_DIV = supv_pkg::OSC_DIV_DEFAULT
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic timing_source_select,
	input wire logic timing_source_input,
	supv_time_if.src tb
);
	logic [1:0] sel_meta;
	logic [1:0] sel_sync;
	logic in_prev;
	logic [15:0] div_count;
	logic ext_edge;
	logic div_done;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sel_meta <= 2'h3;
			sel_sync <= 2'h3;
		end
		else
		begin
			sel_meta <= {timing_source_input, timing_source_select};
			sel_sync <= sel_meta;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			in_prev <= 1'b1;
		else
			in_prev <= sel_sync[1];
	end

	// only rising edges count, so one external period is one clock of the table
	assign ext_edge = sel_sync[1] & ~in_prev;
	assign div_done = (div_count == OSC_DIV - 16'h0001);

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			div_count <= 16'h0000;
		else if (div_done)
			div_count <= 16'h0000;
		else
			div_count <= div_count + 16'h0001;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tb.tick <= 1'b0;
			tb.ext_sel <= 1'b0;
			tb.fast_sel <= 1'b0;
		end
		else
		begin
			tb.ext_sel <= ~sel_sync[0];
			tb.tick <= sel_sync[0] ? div_done : ext_edge;
			tb.fast_sel <= sel_sync[0] & ~sel_sync[1];
		end
	end
endmodule // supv_timebase

// *** supv_top.sv ***
// supervisor core: reset sequencing, watchdog, supply flags and register slave
`timescale 1ns/10ps
module supv_top #(
	parameter logic [15:0] OSC_DIV = supv_pkg::OSC_DIV_DEFAULT,
	parameter logic [15:0] WD_LONG_TICKS = supv_pkg::WD_LONG_TICKS_DEFAULT
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic supply_low_in,
	input wire logic vcc_below_backup_in,
	input wire logic timing_source_select,
	input wire logic timing_source_input,
	input wire logic watchdog_kick_in,
	input wire logic watchdog_kick_valid,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic reset_n_out,
	output logic reset_out,
	output logic supply_low_n_out,
	output logic backup_selected_flag,
	output logic watchdog_expired_out_n,
	output logic irq
);
	supv_time_if tb ();
	supv_pkg::supv_rst_state_t state;
	supv_pkg::supv_rst_state_t next_state;
	logic [3:0] in_meta;
	logic [3:0] in_sync;
	logic supply_low_s;
	logic vcc_below_s;
	logic kick_s;
	logic kick_valid_s;
	logic kick_prev;
	logic kick_edge;
	logic supply_low_prev;
	logic [15:0] rst_count;
	logic [15:0] wd_count;
	logic [15:0] wd_period;
	logic [15:0] rst_period;
	logic wd_long;
	logic wd_enabled;
	logic wd_expire;
	logic [3:0] event_set;
	logic [3:0] event_status;
	logic [3:0] event_enable;
	logic [3:0] event_clear;
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire;
	logic [31:0] status_word;

	// register index check shared by read and write paths
	function automatic logic is_reg(input logic [7:0] addr, input logic [7:0] offset);
		is_reg = (addr[7:2] == offset[7:2]);
	endfunction

	supv_timebase #(
		.OSC_DIV(OSC_DIV)
	) u_timebase (
		.clk(clk),
		.arst_n(arst_n),
		.timing_source_select(timing_source_select),
		.timing_source_input(timing_source_input),
		.tb(tb)
	);

	// comparator and kick levels are asynchronous to clk
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			in_meta <= 4'h1;
			in_sync <= 4'h1;
		end
		else
		begin
			in_meta <= {watchdog_kick_valid, watchdog_kick_in, vcc_below_backup_in,
				supply_low_in};
			in_sync <= in_meta;
		end
	end

	assign supply_low_s = in_sync[0];
	assign vcc_below_s = in_sync[1];
	assign kick_s = in_sync[2];
	assign kick_valid_s = in_sync[3];
	assign kick_edge = kick_valid_s & (kick_s ^ kick_prev);

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			kick_prev <= 1'b0;
			supply_low_prev <= 1'b1;
		end
		else
		begin
			kick_prev <= kick_s;
			supply_low_prev <= supply_low_s;
		end
	end

	always_comb
	begin
		rst_period = tb.ext_sel ? supv_pkg::EXT_RESET_CLKS : supv_pkg::RESET_TICKS;
		if (tb.ext_sel)
			wd_period = wd_long ? supv_pkg::EXT_WD_AFTER_RESET_CLKS
				: supv_pkg::EXT_WD_NORMAL_CLKS;
		else if (wd_long || !tb.fast_sel)
			wd_period = WD_LONG_TICKS;
		else
			wd_period = supv_pkg::WD_SHORT_TICKS;
	end

	assign wd_enabled = (state == supv_pkg::SUPV_RUN) && kick_valid_s;
	// a kick edge in the expiry cycle wins and restarts the count
	assign wd_expire = wd_enabled && !kick_edge && !supply_low_s && tb.tick
		&& (wd_count >= wd_period - 16'h0001);

	always_comb
	begin
		next_state = state;
		case (state)
			supv_pkg::SUPV_HOLD:
				if (!supply_low_s)
					next_state = supv_pkg::SUPV_DELAY;
			supv_pkg::SUPV_DELAY:
				if (supply_low_s)
					next_state = supv_pkg::SUPV_HOLD;
				else if (tb.tick && rst_count >= rst_period - 16'h0001)
					next_state = supv_pkg::SUPV_RUN;
			supv_pkg::SUPV_RUN:
				if (supply_low_s)
					next_state = supv_pkg::SUPV_HOLD;
				else if (wd_expire)
					next_state = supv_pkg::SUPV_DELAY;
			default:
				next_state = supv_pkg::SUPV_HOLD;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			state <= supv_pkg::SUPV_HOLD;
		else
			state <= next_state;
	end

	// delay counter restarts on every entry to the delay state
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rst_count <= 16'h0000;
		else if (next_state != supv_pkg::SUPV_DELAY || state != supv_pkg::SUPV_DELAY)
			rst_count <= 16'h0000;
		else if (tb.tick)
			rst_count <= rst_count + 16'h0001;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			wd_count <= 16'h0000;
		else if (!wd_enabled || kick_edge || wd_expire)
			wd_count <= 16'h0000;
		else if (tb.tick)
			wd_count <= wd_count + 16'h0001;
	end

	// long period armed by any reset, dropped by the first kick after release
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			wd_long <= 1'b1;
		else if (state != supv_pkg::SUPV_RUN)
			wd_long <= 1'b1;
		else if (kick_edge)
			wd_long <= 1'b0;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			reset_n_out <= 1'b0;
			reset_out <= 1'b1;
		end
		else
		begin
			reset_n_out <= (next_state == supv_pkg::SUPV_RUN);
			reset_out <= (next_state != supv_pkg::SUPV_RUN);
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			supply_low_n_out <= 1'b0;
			backup_selected_flag <= 1'b0;
		end
		else
		begin
			supply_low_n_out <= ~supply_low_s;
			backup_selected_flag <= supply_low_s & vcc_below_s;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			watchdog_expired_out_n <= 1'b1;
		else if (supply_low_s)
			watchdog_expired_out_n <= 1'b1;
		else if (wd_expire)
			watchdog_expired_out_n <= 1'b0;
		else if (kick_edge || !kick_valid_s)
			watchdog_expired_out_n <= 1'b1;
	end

	assign event_set[supv_pkg::EV_WD_EXPIRE] = wd_expire;
	assign event_set[supv_pkg::EV_SUPPLY_LOW] = supply_low_s & ~supply_low_prev;
	assign event_set[supv_pkg::EV_RESET_RELEASE] = (state == supv_pkg::SUPV_DELAY)
		&& (next_state == supv_pkg::SUPV_RUN);
	assign event_set[supv_pkg::EV_BACKUP] = supply_low_s & vcc_below_s & ~backup_selected_flag;

	// a new event beats a clear in the same cycle
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			event_status <= 4'h0;
		else
			event_status <= (event_status & ~event_clear) | event_set;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			irq <= 1'b0;
		else
			irq <= |(event_status & event_enable);
	end

	// write address and data may arrive in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end
		else if (wr_fire)
			aw_held <= 1'b0;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		else if (wr_fire)
			w_held <= 1'b0;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= supv_pkg::RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (is_reg(aw_addr, supv_pkg::REG_EVENT_CLEAR)
				|| is_reg(aw_addr, supv_pkg::REG_EVENT_ENABLE))
				? supv_pkg::RESP_OKAY : supv_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	assign event_clear = (wr_fire && w_strb[0] && is_reg(aw_addr, supv_pkg::REG_EVENT_CLEAR))
		? w_data[3:0] : 4'h0;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			event_enable <= supv_pkg::EVENT_ENABLE_RESET;
		else if (wr_fire && w_strb[0] && is_reg(aw_addr, supv_pkg::REG_EVENT_ENABLE))
			event_enable <= w_data[3:0];
	end

	assign status_word = {25'h0000000, wd_long, tb.ext_sel, watchdog_expired_out_n,
		backup_selected_flag, supply_low_n_out, reset_out, reset_n_out};
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= supv_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= supv_pkg::RESP_OKAY;
			if (is_reg(s_axi_araddr, supv_pkg::REG_STATUS))
				s_axi_rdata <= status_word;
			else if (is_reg(s_axi_araddr, supv_pkg::REG_EVENT))
				s_axi_rdata <= {28'h0000000, event_status};
			else if (is_reg(s_axi_araddr, supv_pkg::REG_EVENT_ENABLE))
				s_axi_rdata <= {28'h0000000, event_enable};
			else if (is_reg(s_axi_araddr, supv_pkg::REG_EVENT_CLEAR))
				s_axi_rdata <= 32'h00000000;
			else
			begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= supv_pkg::RESP_SLVERR;
			end
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule // supv_top

// *** supv_checker.sv ***
// port-level assertions for the supervisor core
`timescale 1ns/10ps
module supv_checker (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic supply_low_in,
	input wire logic watchdog_kick_in,
	input wire logic watchdog_kick_valid,
	input wire logic reset_n_out,
	input wire logic reset_out,
	input wire logic supply_low_n_out,
	input wire logic backup_selected_flag,
	input wire logic watchdog_expired_out_n
);
	logic [11:0] low_cnt;
	logic [3:0] since_ev;
	logic kick_d;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	sequence s_low;
		supply_low_in [*4];
	endsequence
	sequence s_high;
		!supply_low_in [*4];
	endsequence
	// saturating counts, so a long run never wraps into a false pass
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			low_cnt <= 12'h000;
		else if (reset_n_out)
			low_cnt <= 12'h000;
		else if (low_cnt != 12'hFFF)
			low_cnt <= low_cnt + 12'h001;
	end
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			kick_d <= 1'h0;
			since_ev <= 4'hF;
		end
		else
		begin
			kick_d <= watchdog_kick_in;
			if (kick_d != watchdog_kick_in || supply_low_in || !watchdog_kick_valid)
				since_ev <= 4'h0;
			else if (since_ev != 4'hF)
				since_ev <= since_ev + 4'h1;
		end
	end
	chk_rst_compl: assert property (reset_out == !reset_n_out)
		else $error("reset outputs not complementary");
	chk_low_flag: assert property (s_low |=> !supply_low_n_out)
		else $error("supply-low flag not low");
	chk_rst_hold: assert property (s_low |=> !reset_n_out)
		else $error("reset not held in low supply");
	chk_backup_off: assert property (s_high |=> !backup_selected_flag)
		else $error("backup selected with good supply");
	chk_wdo_supply: assert property (s_low |=> watchdog_expired_out_n)
		else $error("watchdog output not forced high");
	chk_wdo_idle: assert property (!watchdog_kick_valid [*4] |=> watchdog_expired_out_n)
		else $error("watchdog output low while disabled");
	chk_wdo_cause: assert property ($rose(watchdog_expired_out_n) |-> since_ev < 4'h8)
		else $error("watchdog output rose without a cause");
	// internal ticks are 4 clocks and external ones at least 2, so 512 ticks span at least 1024 clocks
	chk_rel_delay: assert property ($rose(reset_n_out) |-> low_cnt >= 12'h400)
		else $error("reset released too early");
	chk_exp_reset: assert property ($fell(watchdog_expired_out_n) |-> ##[0:3] !reset_n_out)
		else $error("expiry without reset pulse");
endmodule // supv_checker
bind supv_top supv_checker u_chk (.clk, .arst_n, .supply_low_in, .watchdog_kick_in,
	.watchdog_kick_valid, .reset_n_out, .reset_out, .supply_low_n_out, .backup_selected_flag,
	.watchdog_expired_out_n);

// *** supv_cpu_model.sv ***
// processor model that services the watchdog
`timescale 1ns/10ps
module supv_cpu_model (
	input wire logic clk,
	input wire logic reset_n_out,
	input wire logic kick_en,
	input wire logic [7:0] kick_gap,
	output logic watchdog_kick_in
);
	logic [7:0] cnt;
	initial
	begin
		watchdog_kick_in = 1'h0;
		cnt = 8'h00;
	end
	// a stalled or resetting processor leaves the kick line steady
	always @(posedge clk)
	begin
		if (!reset_n_out || !kick_en)
			cnt <= 8'h00;
		else if (cnt >= kick_gap)
		begin
			cnt <= 8'h00;
			watchdog_kick_in <= !watchdog_kick_in;
		end
		else
			cnt <= cnt + 8'h01;
	end
endmodule // supv_cpu_model

// *** testbench.sv ***
// self-checking bench for the supervisor core
`timescale 1ns/10ps
module testbench;
	logic clk, arst_n, supply_low_in, vcc_below_backup_in, timing_source_select, tsi_lvl;
	logic watchdog_kick_valid, kick_en, ext_run, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, reset_n_out, reset_out, supply_low_n_out;
	logic backup_selected_flag, watchdog_expired_out_n, irq, watchdog_kick_in;
	logic [7:0] s_axi_awaddr, s_axi_araddr, kick_gap;
	logic [31:0] s_axi_wdata, s_axi_rdata, rnd, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [2:0] ecnt;
	int n_mismatch, cmp_count, n;
	wire logic timing_source_input = ext_run ? ecnt[2] : tsi_lvl;
	wire logic [3:0] pins = {reset_n_out, supply_low_n_out, backup_selected_flag,
		watchdog_expired_out_n};
	supv_top #(.OSC_DIV(16'h0004), .WD_LONG_TICKS(16'h0040)) dut (.clk, .arst_n, .supply_low_in,
		.vcc_below_backup_in, .timing_source_select, .timing_source_input, .watchdog_kick_in,
		.watchdog_kick_valid, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .reset_n_out, .reset_out, .supply_low_n_out, .backup_selected_flag,
		.watchdog_expired_out_n, .irq);
	supv_cpu_model cpu (.clk, .reset_n_out, .kick_en, .kick_gap, .watchdog_kick_in);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", s, e, g);
		end
	endtask
	// only the bench timeout ends a wait; one idle edge keeps back-to-back calls apart
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do
		begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do
		begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
		@(posedge clk);
	endtask
	task automatic wt(input logic wd, input logic lvl, input int lim);
		n = 0;
		while ((wd ? watchdog_expired_out_n : reset_n_out) !== lvl && n < lim)
		begin
			@(posedge clk);
			n++;
		end
	endtask
	task summarize;
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	// external timing clock of eight system cycles
	always @(posedge clk)
		ecnt <= ecnt + 3'h1;
	initial
	begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		summarize();
	end
	initial
	begin
		{arst_n, vcc_below_backup_in, watchdog_kick_valid, kick_en, ext_run} = 5'h00;
		{supply_low_in, timing_source_select, tsi_lvl} = 3'h7;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, kick_gap, ecnt} = 27'h0000200;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		n_mismatch = 0;
		cmp_count = 0;
		rnd = 32'h0F607E17;
		repeat (10) @(posedge clk);
		arst_n <= 1'h1;
		@(posedge clk);
		rd(supv_pkg::REG_EVENT_ENABLE);
		chk("enable_rst", {28'h0, supv_pkg::EVENT_ENABLE_RESET}, d);
		rd(8'h40);
		chk("unmapped", {30'h0, supv_pkg::RESP_SLVERR}, {30'h0, r});
		wr(supv_pkg::REG_STATUS, 32'h1);
		chk("ro_write", {30'h0, supv_pkg::RESP_SLVERR}, {30'h0, r});
		rnd = lfsr(rnd);
		wr(supv_pkg::REG_EVENT_ENABLE, rnd);
		rd(supv_pkg::REG_EVENT_ENABLE);
		chk("enable_rw", {28'h0, rnd[3:0]}, d);
		wr(supv_pkg::REG_EVENT_ENABLE, 32'h1);
		supply_low_in <= 1'h0;
		wt(1'h0, 1'h1, 3000);
		chk("release", 32'h1, n >= 2036 && n <= 2060);
		chk("run_pins", 32'hD, pins);
		chk("rst_high", 32'h0, reset_out);
		rd(supv_pkg::REG_STATUS);
		chk("status", 32'h55, d);
		rd(supv_pkg::REG_EVENT);
		chk("rel_event", 32'h1, d[2]);
		chk("irq_masked", 32'h0, irq);
		watchdog_kick_valid <= 1'h1;
		wt(1'h1, 1'h0, 600);
		chk("long_expiry", 32'h1, n >= 248 && n <= 275);
		repeat (4) @(posedge clk);
		chk("exp_reset", 32'h1, !reset_n_out && irq);
		wr(supv_pkg::REG_EVENT_CLEAR, 32'h1);
		repeat (2) @(posedge clk);
		chk("irq_clear", 32'h0, irq);
		wt(1'h0, 1'h1, 3000);
		chk("exp_width", 32'h1, n >= 2020 && n <= 2060);
		chk("wdo_held", 32'h0, watchdog_expired_out_n);
		kick_en <= 1'h1;
		wt(1'h1, 1'h1, 200);
		chk("wdo_kick", 32'h1, watchdog_expired_out_n);
		repeat (20)
		begin
			rnd = lfsr(rnd);
			kick_gap <= 8'h14 + {2'h0, rnd[5:0]};
			repeat (150) @(posedge clk);
			chk("kicked", 32'h1, watchdog_expired_out_n & reset_n_out);
		end
		tsi_lvl <= 1'h0;
		repeat (200) @(posedge clk);
		kick_en <= 1'h0;
		wt(1'h1, 1'h0, 5000);
		chk("short_expiry", 32'h1, n >= 3995 && n <= 4110);
		watchdog_kick_valid <= 1'h0;
		repeat (5) @(posedge clk);
		chk("wdo_idle", 32'h1, watchdog_expired_out_n);
		{watchdog_kick_valid, vcc_below_backup_in, supply_low_in} <= 3'h7;
		repeat (6) @(posedge clk);
		chk("low_pins", 32'h3, pins);
		rd(supv_pkg::REG_EVENT);
		chk("low_events", 32'hF, d);
		vcc_below_backup_in <= 1'h0;
		repeat (6) @(posedge clk);
		chk("backup_off", 32'h0, backup_selected_flag);
		{timing_source_select, ext_run, supply_low_in} <= 3'h2;
		wt(1'h0, 1'h1, 6000);
		chk("ext_release", 32'h1, n >= 4080 && n <= 4120);
		wt(1'h1, 1'h0, 34000);
		chk("ext_expiry", 32'h1, n >= 32750 && n <= 32800);
		summarize();
	end
endmodule // testbench
